// ---- sto_pkg.sv ----
package sto_pkg;

  // Relay function selection code that ties a relay to the torque-off state
  localparam logic [7:0] RELAY_FN_TORQUE_OFF = 8'h0D;
  // Trip code for an internal channel fault (29 decimal)
  localparam logic [7:0] TRIP_CHANNEL_FAULT = 8'h1D;
  localparam logic [7:0] TRIP_NONE = 8'h00;

  // Timing, in nanoseconds, at a 50 ns clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MONITOR_LIMIT_NS = 20000000;
  localparam int unsigned REMOVE_LIMIT_NS = 1000000;
  localparam int unsigned MONITOR_LIMIT_CYC = MONITOR_LIMIT_NS / CLK_PERIOD_NS;
  localparam int unsigned REMOVE_LIMIT_CYC = REMOVE_LIMIT_NS / CLK_PERIOD_NS;
  // Channel disagreement tolerated before a fault trip, in nanoseconds
  localparam int unsigned DISCORD_NS = 10000000;
  localparam int unsigned DISCORD_CYC = DISCORD_NS / CLK_PERIOD_NS;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_TRIP = 8'h10;

  // CTRL field positions
  localparam int CTRL_RELAY1_LSB = 0;
  localparam int CTRL_RELAY2_LSB = 8;
  localparam int CTRL_START_SRC_LSB = 16;
  localparam int CTRL_EDGE_MODE_BIT = 24;
  localparam int CTRL_TRIP_RESET_BIT = 25;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt event bit positions
  localparam int IRQ_TORQUE_OFF = 0;
  localparam int IRQ_TORQUE_ON = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [3:0] {
    STO_STANDBY = 4'b0001,
    STO_RUN = 4'b0010,
    STO_OFF = 4'b0100,
    STO_TRIP = 4'b1000
  } sto_state_t;

  typedef enum logic [1:0] {
    STO_DISP_STOP = 2'h0,
    STO_DISP_RUN = 2'h1,
    STO_DISP_INHIBIT = 2'h2,
    STO_DISP_TRIP = 2'h3
  } sto_disp_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sto_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sto_apb_rsp_t;

endpackage

// ---- sto_sync.sv ----
`timescale 1ns/100ps
// Two-flop synchroniser for one torque-enable channel
module sto_sync (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic d, // Raw level
  output logic q // Synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sto_sync_st_t;
  sto_sync_st_t st_q;
  sto_sync_st_t st_d;

  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule

// ---- sto_supervisor.sv ----
`timescale 1ns/100ps
// Behaviour
// - Energised inputs: standby, start on command
// - De-energised inputs: remove torque, motor coasts
// - Show inhibit when inputs de-energised
// - Trip display overrides inhibit display
// - Relay one opens if selection 13
// - Relay two opens if selection 13
// - Channel fault trips with code 29
// - Monitoring status changes within 20 ms
// - Fault shown, healthy dropped within 20 ms
// - Re-energised may restart per start config
// - No braking applied, torque only removed
// - Torque-off function always enabled
// - Edge mode starts only on rising run
module sto_supervisor
  import sto_pkg::*;
#(
  parameter int unsigned DISCORD_CYCLES = DISCORD_CYC
)(
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire sto_pkg::sto_apb_req_t apb_req, // APB request
  output sto_pkg::sto_apb_rsp_t apb_rsp, // APB response
  input wire logic enable_ch_a, // Torque-enable channel A
  input wire logic enable_ch_b, // Torque-enable channel B
  input wire logic [3:0] start_cmd, // Run commands, one per source
  output logic gate_enable, // Power stage gate permit
  output logic brake_active, // Brake request, never set
  output logic relay_one_closed, // Relay one contact
  output logic relay_two_closed, // Relay two contact
  output logic drive_healthy, // Digital healthy output
  output logic safe_torque_off, // Monitoring status
  output sto_pkg::sto_disp_t display_code, // Display selector
  output logic [7:0] trip_code, // Trip number shown
  output logic irq // Interrupt, level
);
  import sto_pkg::*;

  // Elaboration-time range check of the discord window
  if (DISCORD_CYCLES < 2 || DISCORD_CYCLES >= MONITOR_LIMIT_CYC)
  begin : g_bad_discord
    $error("DISCORD_CYCLES out of range");
  end

  typedef struct packed {
    sto_state_t state;
    logic [31:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] discord_cnt;
    logic run_prev;
    logic relay1;
    logic relay2;
    logic healthy;
    logic sto_flag;
    sto_disp_t disp;
    logic [7:0] trip;
    logic [31:0] rdata;
  } sto_st_t;

  sto_st_t st_q;
  sto_st_t st_d;
  logic ena_s;
  logic enb_s;
  logic both_on;
  logic run_cmd;
  logic run_rise;
  logic start_ok;
  logic chan_fault;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [IRQ_W-1:0] ev;

  function automatic logic relay_open(input logic [7:0] sel, input logic sto_on);
    relay_open = (sel == RELAY_FN_TORQUE_OFF) && sto_on;
  endfunction

  sto_sync u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .d(enable_ch_a),
    .q(ena_s)
  );

  sto_sync u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .d(enable_ch_b),
    .q(enb_s)
  );

  assign both_on = ena_s && enb_s;
  assign chan_fault = (ena_s != enb_s) && (st_q.discord_cnt >= DISCORD_CYCLES - 1);
  assign run_cmd = start_cmd[st_q.ctrl[CTRL_START_SRC_LSB +: 2]];
  assign run_rise = run_cmd && !st_q.run_prev;
  assign start_ok = st_q.ctrl[CTRL_EDGE_MODE_BIT] ? run_rise : run_cmd;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign addr_ok = apb_req.paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_TRIP};

  always_comb
  begin
    st_d = st_q;
    ev = '0;
    st_d.run_prev = run_cmd;
    if (ena_s != enb_s)
      st_d.discord_cnt = st_q.discord_cnt + 32'h0000_0001;
    else
      st_d.discord_cnt = 32'h0000_0000;
    unique case (st_q.state)
      STO_STANDBY:
      begin
        if (chan_fault)
          st_d.state = STO_TRIP;
        else if (!both_on)
          st_d.state = STO_OFF;
        else if (start_ok)
          st_d.state = STO_RUN;
      end
      STO_RUN:
      begin
        if (chan_fault)
          st_d.state = STO_TRIP;
        else if (!both_on)
          st_d.state = STO_OFF;
        else if (!run_cmd)
          st_d.state = STO_STANDBY;
      end
      STO_OFF:
      begin
        if (chan_fault)
          st_d.state = STO_TRIP;
        else if (both_on)
          st_d.state = STO_STANDBY;
      end
      STO_TRIP:
      begin
        if (wr_en && apb_req.paddr == ADDR_CTRL && apb_req.pwdata[CTRL_TRIP_RESET_BIT] && ena_s == enb_s)
          st_d.state = both_on ? STO_STANDBY : STO_OFF;
      end
    endcase
    // Monitoring follows synchronised inputs each cycle, well under 20 ms
    st_d.sto_flag = !both_on;
    st_d.relay1 = !relay_open(st_q.ctrl[CTRL_RELAY1_LSB +: 8], !both_on);
    st_d.relay2 = !relay_open(st_q.ctrl[CTRL_RELAY2_LSB +: 8], !both_on);
    st_d.healthy = (st_d.state != STO_TRIP);
    if (st_d.state == STO_TRIP)
    begin
      st_d.disp = STO_DISP_TRIP;
      st_d.trip = TRIP_CHANNEL_FAULT;
    end
    else
    begin
      st_d.trip = TRIP_NONE;
      if (!both_on)
        st_d.disp = STO_DISP_INHIBIT;
      else if (st_d.state == STO_RUN)
        st_d.disp = STO_DISP_RUN;
      else
        st_d.disp = STO_DISP_STOP;
    end
    if (st_q.state != STO_OFF && st_d.state == STO_OFF)
      ev[IRQ_TORQUE_OFF] = 1'b1;
    if (st_q.state == STO_OFF && st_d.state == STO_STANDBY)
      ev[IRQ_TORQUE_ON] = 1'b1;
    if (st_q.state != STO_TRIP && st_d.state == STO_TRIP)
      ev[IRQ_FAULT] = 1'b1;
    // Write-one-to-clear; a new event wins over the clear
    if (wr_en && apb_req.paddr == ADDR_IRQ_STAT)
      st_d.irq_stat = st_q.irq_stat & ~apb_req.pwdata[IRQ_W-1:0];
    st_d.irq_stat = st_d.irq_stat | ev;
    if (wr_en && apb_req.paddr == ADDR_IRQ_MASK)
      st_d.irq_mask = apb_req.pwdata[IRQ_W-1:0];
    if (wr_en && apb_req.paddr == ADDR_CTRL)
      st_d.ctrl = {7'h00, apb_req.pwdata[24:0]};
    if (rd_en)
    begin
      unique case (apb_req.paddr)
        ADDR_CTRL: st_d.rdata = st_q.ctrl;
        ADDR_STATUS: st_d.rdata = {22'h000000, st_q.disp, st_q.state, st_q.healthy, st_q.sto_flag, enb_s, ena_s};
        ADDR_IRQ_STAT: st_d.rdata = {29'h00000000, st_q.irq_stat};
        ADDR_IRQ_MASK: st_d.rdata = {29'h00000000, st_q.irq_mask};
        ADDR_TRIP: st_d.rdata = {24'h000000, st_q.trip};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.state <= STO_OFF;
      st_q.ctrl <= CTRL_RESET;
      st_q.irq_stat <= '0;
      st_q.irq_mask <= '0;
      st_q.discord_cnt <= 32'h0000_0000;
      st_q.run_prev <= 1'b1;
      st_q.relay1 <= 1'b0;
      st_q.relay2 <= 1'b0;
      st_q.healthy <= 1'b0;
      st_q.sto_flag <= 1'b1;
      st_q.disp <= STO_DISP_INHIBIT;
      st_q.trip <= TRIP_NONE;
      st_q.rdata <= 32'h0000_0000;
    end
    else
      st_q <= st_d;
  end

  // Raw pins gate torque directly, so removal never waits on sync
  assign gate_enable = (st_q.state == STO_RUN) && enable_ch_a && enable_ch_b;
  assign brake_active = 1'b0;
  assign relay_one_closed = st_q.relay1;
  assign relay_two_closed = st_q.relay2;
  assign drive_healthy = st_q.healthy;
  assign safe_torque_off = st_q.sto_flag;
  assign display_code = st_q.disp;
  assign trip_code = st_q.trip;
  assign irq = |(st_q.irq_stat & st_q.irq_mask);
  assign apb_rsp = '{prdata: st_q.rdata, pready: 1'b1, pslverr: apb_req.psel && apb_req.penable && !addr_ok};
endmodule

// ---- sto_supervisor_checker.sv ----
`timescale 1ns/100ps
module sto_supervisor_checker
  import sto_pkg::*;
#(
  parameter int unsigned DISCORD_CYCLES = 8
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic enable_ch_a, // Channel A
  input wire logic enable_ch_b, // Channel B
  input wire logic gate_enable, // Gate
  input wire logic brake_active, // Brake
  input wire logic drive_healthy, // Healthy
  input wire logic safe_torque_off, // Status
  input wire sto_pkg::sto_disp_t display_code, // Display
  input wire logic [7:0] trip_code // Trip
);
  int unsigned disc_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles of channel disagreement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      disc_q <= 0;
    else
      disc_q <= (enable_ch_a != enable_ch_b) ? disc_q + 1 : 0;
  end
  chk_gate_off: assert property (!(enable_ch_a && enable_ch_b) |-> !gate_enable)
    else $error("gate on with a channel off");
  chk_no_brake: assert property (!brake_active)
    else $error("brake raised");
  chk_sto_set: assert property (!(enable_ch_a && enable_ch_b) |-> ##3 safe_torque_off)
    else $error("status not set");
  chk_sto_clear: assert property (enable_ch_a && enable_ch_b |-> ##3 !safe_torque_off)
    else $error("status not cleared");
  chk_inhibit_show: assert property (safe_torque_off && trip_code == TRIP_NONE |-> display_code == STO_DISP_INHIBIT)
    else $error("inhibit not shown");
  chk_trip_show: assert property (trip_code != TRIP_NONE |-> display_code == STO_DISP_TRIP)
    else $error("trip not shown");
  chk_trip_gate: assert property (trip_code != TRIP_NONE |-> !gate_enable)
    else $error("gate on in trip");
  chk_fault_trip: assert property (disc_q == DISCORD_CYCLES |-> ##[0:6] (trip_code == TRIP_CHANNEL_FAULT && !drive_healthy))
    else $error("no fault trip");
endmodule
bind sto_supervisor sto_supervisor_checker #(.DISCORD_CYCLES(DISCORD_CYCLES)) u_sto_supervisor_checker (
  .pclk, .presetn, .enable_ch_a, .enable_ch_b, .gate_enable, .brake_active,
  .drive_healthy, .safe_torque_off, .display_code, .trip_code
);

// ---- sto_relay_model.sv ----
`timescale 1ns/100ps
module sto_relay_model (
  input wire logic pclk, // Clock
  input wire logic energise, // Close contacts
  input wire logic stuck_b, // Weld contact B
  output logic enable_ch_a, // Contact A
  output logic enable_ch_b // Contact B
);
  initial
  begin
    enable_ch_a = 1'b0;
    enable_ch_b = 1'b0;
  end
  always @(posedge pclk)
  begin
    enable_ch_a <= energise;
    enable_ch_b <= energise | stuck_b;
  end
endmodule

// ---- sto_supervisor_test.sv ----
`timescale 1ns/100ps
module sto_supervisor_test;
  import sto_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic energise = 1'b0;
  logic stuck_b = 1'b0;
  logic [3:0] start_cmd = 4'h0;
  sto_apb_req_t apb_req = '0;
  sto_apb_rsp_t apb_rsp;
  logic enable_ch_a, enable_ch_b, gate_enable, brake_active, relay_one_closed, relay_two_closed;
  logic drive_healthy, safe_torque_off, irq;
  sto_disp_t display_code;
  logic [7:0] trip_code;
  int errors = 0;
  int checked = 0;
  always #25 pclk = ~pclk;
  sto_relay_model u_sto_relay_model (.pclk, .energise, .stuck_b, .enable_ch_a, .enable_ch_b);
  sto_supervisor #(.DISCORD_CYCLES(8)) u_sto_supervisor (
    .pclk, .presetn, .apb_req, .apb_rsp, .enable_ch_a, .enable_ch_b, .start_cmd, .gate_enable,
    .brake_active, .relay_one_closed, .relay_two_closed, .drive_healthy, .safe_torque_off,
    .display_code, .trip_code, .irq
  );
  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Response word is {pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    r = {apb_rsp.pslverr, apb_rsp.prdata};
    apb_req <= '0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp, input string what);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp, what);
  endtask
  task report_and_stop;
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(12);
    check(display_code, STO_DISP_INHIBIT, "reset display");
    @(posedge pclk) presetn <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_000D);
    wr(ADDR_IRQ_MASK, 32'h0000_0004);
    cyc(2);
    check({relay_one_closed, relay_two_closed, gate_enable}, 3'b010, "relay one");
    wr(ADDR_CTRL, 32'h0000_0D00);
    cyc(2);
    check({relay_one_closed, relay_two_closed}, 2'b10, "relay two");
    rd(ADDR_CTRL, 33'h0_0000_0D00, "ctrl");
    @(posedge pclk) energise <= 1'b1;
    cyc(6);
    rd(ADDR_STATUS, 33'h0_0000_001B, "standby");
    @(posedge pclk) start_cmd <= 4'h1;
    cyc(3);
    check({gate_enable, relay_two_closed, display_code}, 4'b1101, "run");
    @(posedge pclk) energise <= 1'b0;
    cyc(1);
    check({gate_enable, brake_active}, 2'b00, "gate drop");
    cyc(3);
    check({safe_torque_off, display_code, brake_active, irq}, 5'b11000, "coast");
    @(posedge pclk) energise <= 1'b1;
    cyc(6);
    check(gate_enable, 1'b1, "auto restart");
    wr(ADDR_CTRL, 32'h0102_0D00);
    @(posedge pclk) energise <= 1'b0;
    @(posedge pclk) start_cmd <= 4'h4;
    cyc(5);
    @(posedge pclk) energise <= 1'b1;
    cyc(6);
    check(gate_enable, 1'b0, "held level");
    @(posedge pclk) start_cmd <= 4'h0;
    @(posedge pclk) start_cmd <= 4'h4;
    cyc(3);
    check(gate_enable, 1'b1, "edge start");
    @(posedge pclk) start_cmd <= 4'h0;
    @(posedge pclk)
    begin
      energise <= 1'b0;
      stuck_b <= 1'b1;
    end
    cyc(20);
    check({trip_code, display_code, drive_healthy, irq}, 12'h1DD, "fault trip");
    rd(ADDR_TRIP, 33'h0_0000_001D, "trip reg");
    rd(ADDR_IRQ_STAT, 33'h0_0000_0007, "irq stat");
    wr(ADDR_IRQ_STAT, 32'h0000_0007);
    cyc(1);
    check(irq, 1'b0, "irq clear");
    rd(8'h14, 33'h1_0000_0000, "unmapped");
    @(posedge pclk) stuck_b <= 1'b0;
    cyc(4);
    wr(ADDR_CTRL, 32'h0200_0D00);
    cyc(2);
    check({trip_code, display_code, drive_healthy}, 11'h005, "trip reset");
    report_and_stop();
  end
  initial
  begin
    repeat (4000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule
